// ---- core/power_retention_regs.sv ----
// Power management register slice with RAM section power and retention control.
// Assumes an Avalon-MM master on clk, supply mode and system-off pins from outside.
module power_retention_regs (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [1:0]  avs_response,
  input  wire logic        supply_on_hv_pin,
  input  wire logic        system_off_pin,
  output logic      [5:0]  hv_trip_decivolt,
  output logic             hv_trip_active,
  output logic             stage_one_switcher_on,
  output logic             stage_zero_switcher_on,
  output logic      [15:0] section_powered,
  output logic      [15:0] section_retained
);
  typedef struct packed {
    power_retention_pkg::bus_state_t bus;
    logic [31:0] readdata;
    logic        waitreq;
    logic [1:0]  response;
    logic        rd_scratch;
    logic [1:0]  hv_sync;
    logic [1:0]  off_sync;
    logic [3:0]  hv_fail_threshold;
    logic        stage_one;
    logic        stage_zero;
    logic [15:0] section_power_bit;
    logic [15:0] section_retention_bit;
    logic [5:0]  trip;
    logic        trip_active;
    logic        stage_one_out;
    logic        stage_zero_out;
    logic [15:0] powered_out;
    logic [15:0] retained_out;
  } regs_t;

  regs_t state;
  regs_t next_state;

  logic [7:0] scratch_rd;
  logic       scratch_wr;
  logic       scratch_wr_sel;
  logic [31:0] wmask;

  // Byte-enable expansion, used for the RAM bank power register and its set and clear aliases
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  // Recognises the addresses this slice answers
  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == power_retention_pkg::power_fail_config_offset)
             || (a == power_retention_pkg::retained_scratch_a_offset)
             || (a == power_retention_pkg::retained_scratch_b_offset)
             || (a == power_retention_pkg::switcher_enable_stage_one_offset)
             || (a == power_retention_pkg::switcher_enable_stage_zero_offset)
             || (a == power_retention_pkg::supply_mode_status_offset)
             || (a == power_retention_pkg::ram_bank_zero_power_offset)
             || (a == power_retention_pkg::bank_power_set_alias_offset)
             || (a == power_retention_pkg::bank_power_clear_alias_offset);
  endfunction : is_mapped

  assign wmask = lane_mask(avs_byteenable);

  // Scratch bytes live in the retained store; write only in idle phase
  assign scratch_wr = (state.bus == power_retention_pkg::bus_idle) && avs_write
                    && avs_byteenable[0]
                    && ((avs_address == power_retention_pkg::retained_scratch_a_offset)
                     || (avs_address == power_retention_pkg::retained_scratch_b_offset));
  assign scratch_wr_sel = (avs_address == power_retention_pkg::retained_scratch_b_offset);

  retained_word_store scratch_store (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (scratch_wr),
    .wr_sel  (scratch_wr_sel),
    .wr_data (avs_writedata[7:0]),
    .rd_sel  (scratch_wr_sel),
    .rd_data (scratch_rd)
  );

  // Bus slave, register updates and registered outputs
  always_comb begin
    logic [31:0] bank_word;
    logic [31:0] rd;
    logic        hv_mode;
    logic        deep_off;
    bank_word  = {state.section_retention_bit, state.section_power_bit};
    rd         = 32'h0000_0000;
    hv_mode    = state.hv_sync[1];
    deep_off   = state.off_sync[1];
    next_state = state;

    // Two-flop synchronisers on the pins
    next_state.hv_sync  = {state.hv_sync[0], supply_on_hv_pin};
    next_state.off_sync = {state.off_sync[0], system_off_pin};

    case (state.bus)
      power_retention_pkg::bus_idle: begin
        next_state.waitreq = 1'b1;
        if (avs_write) begin
          // Reserved bits are dropped by masking to field width
          case (avs_address)
            power_retention_pkg::power_fail_config_offset: begin
              if (avs_byteenable[2]) begin
                next_state.hv_fail_threshold =
                  avs_writedata[power_retention_pkg::hv_fail_threshold_lsb +: 4];
              end
            end
            power_retention_pkg::switcher_enable_stage_one_offset: begin
              if (avs_byteenable[0]) begin
                next_state.stage_one = avs_writedata[0];
              end
            end
            power_retention_pkg::switcher_enable_stage_zero_offset: begin
              if (avs_byteenable[0]) begin
                next_state.stage_zero = avs_writedata[0];
              end
            end
            power_retention_pkg::ram_bank_zero_power_offset: begin
              bank_word = (bank_word & ~wmask) | (avs_writedata & wmask);
            end
            power_retention_pkg::bank_power_set_alias_offset: begin
              bank_word = bank_word | (avs_writedata & wmask);
            end
            power_retention_pkg::bank_power_clear_alias_offset: begin
              bank_word = bank_word & ~(avs_writedata & wmask);
            end
            default: begin
              bank_word = bank_word;
            end
          endcase
          next_state.section_power_bit     = bank_word[15:0];
          next_state.section_retention_bit =
            bank_word[power_retention_pkg::retention_lsb +: 16];
          next_state.response = is_mapped(avs_address) ? 2'b00 : 2'b10;
          next_state.bus      = power_retention_pkg::bus_answer;
          next_state.waitreq  = 1'b0;
        end else if (avs_read && !state.rd_scratch
                     && ((avs_address == power_retention_pkg::retained_scratch_a_offset)
                      || (avs_address == power_retention_pkg::retained_scratch_b_offset))) begin
          // Store read port is registered: hold one cycle so its data match the address
          next_state.rd_scratch = 1'b1;
        end else if (avs_read) begin
          case (avs_address)
            power_retention_pkg::power_fail_config_offset: begin
              rd[power_retention_pkg::hv_fail_threshold_lsb +: 4] = state.hv_fail_threshold;
            end
            power_retention_pkg::switcher_enable_stage_one_offset: begin
              rd[0] = state.stage_one;
            end
            power_retention_pkg::switcher_enable_stage_zero_offset: begin
              rd[0] = state.stage_zero;
            end
            power_retention_pkg::supply_mode_status_offset: begin
              rd[0] = hv_mode;
            end
            power_retention_pkg::ram_bank_zero_power_offset,
            power_retention_pkg::bank_power_set_alias_offset,
            power_retention_pkg::bank_power_clear_alias_offset: begin
              rd = bank_word;
            end
            default: begin
              rd = 32'h0000_0000;
            end
          endcase
          if (state.rd_scratch) begin
            rd = {24'h00_0000, scratch_rd};
          end
          next_state.rd_scratch = 1'b0;
          next_state.readdata = rd;
          next_state.response = is_mapped(avs_address) ? 2'b00 : 2'b10;
          next_state.bus      = power_retention_pkg::bus_answer;
          next_state.waitreq  = 1'b0;
        end
      end
      power_retention_pkg::bus_answer: begin
        // Answer stands one cycle, then back to idle
        next_state.waitreq    = 1'b1;
        next_state.rd_scratch = 1'b0;
        next_state.bus        = power_retention_pkg::bus_idle;
      end
      default: begin
        next_state.bus     = power_retention_pkg::bus_idle;
        next_state.waitreq = 1'b1;
      end
    endcase

    // Comparator trip level, applied only in high-voltage mode
    next_state.trip = power_retention_pkg::hv_trip_base_decivolt
                    + (power_retention_pkg::hv_trip_step_decivolt
                       * {2'b00, state.hv_fail_threshold});
    next_state.trip_active = hv_mode;

    next_state.stage_one_out  = state.stage_one;
    next_state.stage_zero_out = state.stage_zero;

    // System-off overrides power; retention of unpowered sections per bit
    next_state.powered_out  = deep_off ? 16'h0000 : state.section_power_bit;
    next_state.retained_out = next_state.powered_out
                            | state.section_retention_bit;
  end

  // State register; waitrequest high out of reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state                       <= '0;
      state.bus                   <= power_retention_pkg::bus_idle;
      state.waitreq               <= 1'b1;
      state.hv_fail_threshold     <= power_retention_pkg::hv_fail_threshold_reset;
      state.section_power_bit     <= power_retention_pkg::section_power_reset;
      state.section_retention_bit <= power_retention_pkg::section_retention_reset;
      state.trip                  <= power_retention_pkg::hv_trip_base_decivolt;
      state.powered_out           <= power_retention_pkg::section_power_reset;
      state.retained_out          <= power_retention_pkg::section_power_reset;
    end else begin
      state <= next_state;
    end
  end

  assign avs_readdata           = state.readdata;
  assign avs_waitrequest        = state.waitreq;
  assign avs_response           = state.response;
  assign hv_trip_decivolt       = state.trip;
  assign hv_trip_active         = state.trip_active;
  assign stage_one_switcher_on  = state.stage_one_out;
  assign stage_zero_switcher_on = state.stage_zero_out;
  assign section_powered        = state.powered_out;
  assign section_retained       = state.retained_out;
endmodule : power_retention_regs

// ---- core/power_retention_pkg.sv ----
// Package for the power and retention register slice: offsets, fields, resets.
// Assumes a 32-bit Avalon-MM slave with byte addresses and word-aligned registers.
package power_retention_pkg;
  // Register byte offsets
  localparam logic [11:0] power_fail_config_offset          = 12'h510;
  localparam logic [11:0] retained_scratch_a_offset         = 12'h51c;
  localparam logic [11:0] retained_scratch_b_offset         = 12'h520;
  localparam logic [11:0] switcher_enable_stage_one_offset  = 12'h578;
  localparam logic [11:0] switcher_enable_stage_zero_offset = 12'h580;
  localparam logic [11:0] supply_mode_status_offset         = 12'h640;
  localparam logic [11:0] ram_bank_zero_power_offset        = 12'h900;
  localparam logic [11:0] bank_power_set_alias_offset       = 12'h904;
  localparam logic [11:0] bank_power_clear_alias_offset     = 12'h908;
  localparam logic [11:0] system_off_control_offset         = 12'h500;

  // Field positions, widths and counts
  localparam int hv_fail_threshold_lsb = 16;
  localparam int scratch_width         = 8;
  localparam int section_count         = 16;
  localparam int retention_lsb         = 16;

  // Reset values
  localparam logic [3:0]  hv_fail_threshold_reset = 4'h0;
  localparam logic [7:0]  scratch_reset           = 8'h00;
  localparam logic [15:0] section_power_reset     = 16'hffff;
  localparam logic [15:0] section_retention_reset = 16'h0000;

  // Trip level in tenths of a volt for code zero, and step per code
  localparam logic [5:0] hv_trip_base_decivolt = 6'h1b;
  localparam logic [5:0] hv_trip_step_decivolt = 6'h01;

  // Avalon slave phase
  typedef enum logic [1:0] {
    bus_idle   = 2'b01,
    bus_answer = 2'b10
  } bus_state_t;
endpackage : power_retention_pkg

// ---- core/retained_word_store.sv ----
// Small retained register store: holds the two scratch bytes.
// Assumes writes come from the register slave on the same clock.
module retained_word_store (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       wr_en,
  input  wire logic       wr_sel,
  input  wire logic [7:0] wr_data,
  input  wire logic       rd_sel,
  output logic      [7:0] rd_data
);
  typedef struct packed {
    logic [1:0][7:0] word;
    logic [7:0]      rd;
  } store_t;

  store_t state;
  store_t next_state;

  // Write port and registered read port
  always_comb begin
    next_state = state;
    if (wr_en) begin
      next_state.word[wr_sel] = wr_data;
    end
    next_state.rd = state.word[rd_sel];
  end

  // Only the power-on reset clears these, so they survive soft events
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rd_data = state.rd;
endmodule : retained_word_store

// ---- test/power_retention_regs_assertions.sv ----
// Checker for the power and retention register slice.
// Assumes one clock domain; bound to every instance of the top.
module power_retention_regs_assertions (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  input wire logic        supply_on_hv_pin,
  input wire logic        system_off_pin,
  input wire logic [5:0]  hv_trip_decivolt,
  input wire logic        hv_trip_active,
  input wire logic        stage_one_switcher_on,
  input wire logic        stage_zero_switcher_on,
  input wire logic [15:0] section_powered,
  input wire logic [15:0] section_retained
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Request taken by an idle slave, and a write with byte lane 0 enabled to one place
  sequence taken_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence wr_s(logic [11:0] a);
    avs_write && avs_waitrequest && avs_address == a && avs_byteenable[0];
  endsequence
  // Pins pass two sync flops and an output flop, so four samples suffice
  a_answer_next: assert property (taken_s and !(avs_read && (avs_address == 12'h51c
    || avs_address == 12'h520)) |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  a_scratch_answer: assert property (taken_s and avs_read && (avs_address == 12'h51c
    || avs_address == 12'h520) |-> ##[1:2] !avs_waitrequest)
    else $error("scratch read not answered in two cycles");
  a_answer_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than one cycle");
  a_trip_range: assert property (hv_trip_decivolt >= 6'h1b && hv_trip_decivolt <= 6'h2a)
    else $error("trip level out of range");
  a_retain_powered: assert property ((section_retained & section_powered) == section_powered)
    else $error("powered section not retained");
  a_sysoff_unpowered: assert property (system_off_pin [*4] |-> section_powered == 16'h0000)
    else $error("section powered in system off");
  a_hv_mode_on: assert property (supply_on_hv_pin [*4] |-> hv_trip_active)
    else $error("threshold not applied in high voltage mode");
  a_normal_mode_off: assert property (!supply_on_hv_pin [*4] |-> !hv_trip_active)
    else $error("threshold applied in normal mode");
  a_zero_switch_follows: assert property (wr_s(12'h580) |-> ##2
    stage_zero_switcher_on == $past(avs_writedata[0], 2))
    else $error("stage zero switcher does not follow write");
  a_one_switch_follows: assert property (wr_s(12'h578) |-> ##2
    stage_one_switcher_on == $past(avs_writedata[0], 2))
    else $error("stage one switcher does not follow write");
  a_unmapped_err: assert property (taken_s and avs_read && avs_address == 12'h500 |=>
    avs_response == 2'b10 && avs_readdata == 32'h0000_0000)
    else $error("unmapped read not refused");
endmodule : power_retention_regs_assertions

bind power_retention_regs power_retention_regs_assertions u_chk (.clk(clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
  .supply_on_hv_pin(supply_on_hv_pin), .system_off_pin(system_off_pin),
  .hv_trip_decivolt(hv_trip_decivolt), .hv_trip_active(hv_trip_active),
  .stage_one_switcher_on(stage_one_switcher_on), .stage_zero_switcher_on(stage_zero_switcher_on),
  .section_powered(section_powered), .section_retained(section_retained));

// ---- test/tb_power_retention_regs.sv ----
// Self-checking bench for the power and retention register slice.
// Assumes the slave answers each request by dropping avs_waitrequest.
module tb_power_retention_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, avs_read, avs_write, supply_on_hv_pin, system_off_pin;
  logic        avs_waitrequest, hv_trip_active, stage_one_switcher_on, stage_zero_switcher_on;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0]  avs_byteenable;
  logic [1:0]  avs_response, rsp;
  logic [5:0]  hv_trip_decivolt;
  logic [15:0] section_powered, section_retained;
  int          n_errors, compares;

  power_retention_regs dut (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
    .supply_on_hv_pin(supply_on_hv_pin), .system_off_pin(system_off_pin),
    .hv_trip_decivolt(hv_trip_decivolt), .hv_trip_active(hv_trip_active),
    .stage_one_switcher_on(stage_one_switcher_on), .stage_zero_switcher_on(stage_zero_switcher_on),
    .section_powered(section_powered), .section_retained(section_retained));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One bus cycle; request held until waitrequest is seen low
  // Answer is latched before the edge so the edge's own update is never seen
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    logic w;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(negedge clk);
      w = avs_waitrequest;
      rd = avs_readdata;
      rsp = avs_response;
      @(posedge clk);
    end while (w !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(name, rd, exp);
  endtask : rchk

  task automatic t_reset;
    chk("powered", 32'(section_powered), 32'h0000_ffff);
    rchk("scratch_a", 12'h51c, 32'h0000_0000);
    rchk("scratch_b", 12'h520, 32'h0000_0000);
    rchk("sw_one", 12'h578, 32'h0000_0000);
    rchk("sw_zero", 12'h580, 32'h0000_0000);
    rchk("bank", 12'h900, 32'h0000_ffff);
  endtask : t_reset

  // Reserved bits written as ones must read back zero
  task automatic t_scratch_switch;
    bus(1'b1, 12'h51c, 32'hffff_ffa5);
    bus(1'b1, 12'h520, 32'h1234_565a);
    rchk("scratch_a", 12'h51c, 32'h0000_00a5);
    rchk("scratch_b", 12'h520, 32'h0000_005a);
    bus(1'b1, 12'h578, 32'hffff_ffff);
    repeat (2) @(posedge clk);
    chk("sw_pair", 32'({stage_one_switcher_on, stage_zero_switcher_on}), 32'h0000_0002);
    rchk("sw_one", 12'h578, 32'h0000_0001);
    bus(1'b1, 12'h578, 32'hffff_fffe);
    bus(1'b1, 12'h580, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("sw_pair", 32'({stage_one_switcher_on, stage_zero_switcher_on}), 32'h0000_0001);
  endtask : t_scratch_switch

  task automatic t_thresh_mode;
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, 12'h510, 32'hfff0_ffff | (32'(i) << 16));
      repeat (2) @(posedge clk);
      chk("trip", 32'(hv_trip_decivolt), 32'h0000_001b + 32'(i));
      rchk("thresh", 12'h510, 32'(i) << 16);
    end
    for (int m = 1; m >= 0; m--) begin
      supply_on_hv_pin <= 1'(m);
      repeat (5) @(posedge clk);
      chk("active", 32'(hv_trip_active), 32'(m));
      rchk("mode", 12'h640, 32'(m));
    end
  endtask : t_thresh_mode

  // Aliases back to back, then system off over the result
  task automatic t_ram;
    bus(1'b1, 12'h900, 32'h0003_000c);
    bus(1'b1, 12'h904, 32'h0010_0001);
    rchk("set", 12'h900, 32'h0013_000d);
    bus(1'b1, 12'h908, 32'h0001_0004);
    rchk("clear", 12'h908, 32'h0012_0009);
    repeat (2) @(posedge clk);
    chk("powered", 32'(section_powered), 32'h0000_0009);
    chk("retained", 32'(section_retained), 32'h0000_001b);
    system_off_pin <= 1'b1;
    repeat (5) @(posedge clk);
    chk("off_pow", 32'(section_powered), 32'h0000_0000);
    chk("off_ret", 32'(section_retained), 32'h0000_0012);
    system_off_pin <= 1'b0;
    repeat (5) @(posedge clk);
    chk("on_pow", 32'(section_powered), 32'h0000_0009);
  endtask : t_ram

  task automatic t_unmapped;
    bus(1'b1, 12'h500, 32'hffff_ffff);
    rchk("unmapped", 12'h500, 32'h0000_0000);
    chk("resp", 32'(rsp), 32'h0000_0002);
    rchk("hole", 12'h7fc, 32'h0000_0000);
    rchk("bank", 12'h900, 32'h0012_0009);
  endtask : t_unmapped

  task automatic summarize;
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  // Main sequence
  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 12'h000;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hf;
    supply_on_hv_pin = 1'b0;
    system_off_pin = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_scratch_switch;
    t_thresh_mode;
    t_ram;
    t_unmapped;
    summarize;
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    summarize;
  end
endmodule : tb_power_retention_regs
